// [field_oriented_current_loop.sv]
// field-oriented digital current loop with direct pwm outputs
// ============================================================================
// Summary of operation
// - pwm from compare against up/down counter
// - loop uses only digitized adc samples
// - measured currents transformed stator to field frame
// - separate d and q loops, inverse transform
// - pi law, one shared gain set
// - q command from servo output normally
// - override replaces servo with fixed q command
// - d command from per-motor magnitude parameter
// - enable zero means no loop closure
// - device commutates and closes loop, emits pwm
// - loop runs once per phase clock tick that finds a valid sample while idle
// - three complementary top/bottom pairs per channel
module field_oriented_current_loop
  import foc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 phase_tick,
  input  wire logic                 sample_valid,
  input  wire phase_current_t       sample,
  input  wire logic [AW-1:0]        elec_angle,
  input  wire logic signed [DW-1:0] servo_q_cmd,
  input  wire logic                 override_en,
  input  wire logic signed [DW-1:0] override_q_cmd,
  input  wire logic signed [DW-1:0] direct_current_magnitude,
  input  wire logic                 current_loop_enable,
  input  wire gains_t               gains,
  output pwm_pair_t                 pwm_a,
  output pwm_pair_t                 pwm_b,
  output pwm_pair_t                 pwm_c,
  output logic                      loop_busy,
  output dq_t                       meas_dq
);

  // ==========================================================================
  // helpers
  // sine approximation: triangle wave scaled to +/-0x7FFF, cheap and monotonic
  function automatic logic signed [DW-1:0] sin_f(input logic [AW-1:0] a);
    logic [AW-3:0] f;
    logic [DW-1:0] m;
    f = a[AW-3:0];
    m = a[AW-2] ? {1'b0, ~f, 7'h7F} : {1'b0, f, 7'h00};
    sin_f = a[AW-1] ? -$signed(m) : $signed(m);
  endfunction : sin_f

  function automatic logic signed [DW-1:0] sat_f(input logic signed [2*DW-1:0] v);
    if (v > $signed({{DW{1'b0}}, SAT_POS})) begin
      sat_f = SAT_POS;
    end else if (v < $signed({{DW{1'b1}}, SAT_NEG})) begin
      sat_f = SAT_NEG;
    end else begin
      sat_f = v[DW-1:0];
    end
  endfunction : sat_f

  // product of two signed words scaled back by 2^15
  function automatic logic signed [2*DW-1:0] mulq_f(input logic signed [DW-1:0] x,
                                                    input logic signed [DW-1:0] y);
    logic signed [2*DW-1:0] p;
    p = x * y;
    mulq_f = p >>> (DW - 1);
  endfunction : mulq_f

  // ==========================================================================
  // triangle carrier counter
  logic [CW-1:0] carrier;
  logic          count_down;
  logic [CW-1:0] next_carrier;
  logic          next_count_down;

  // counter turns at both ends so the carrier is a symmetric triangle
  always_comb begin
    next_carrier    = carrier;
    next_count_down = count_down;
    if (!count_down) begin
      if (carrier == PWM_MAX) begin
        next_count_down = 1'b1;
        next_carrier    = carrier - 11'h001;
      end else begin
        next_carrier = carrier + 11'h001;
      end
    end else begin
      if (carrier == PWM_ZERO) begin
        next_count_down = 1'b0;
        next_carrier    = carrier + 11'h001;
      end else begin
        next_carrier = carrier - 11'h001;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      carrier    <= PWM_ZERO;
      count_down <= 1'b0;
    end else begin
      carrier    <= next_carrier;
      count_down <= next_count_down;
    end
  end

  // ==========================================================================
  // loop sequencer and arithmetic
  seq_state_t             state;
  seq_state_t             next_state;
  phase_current_t         held;
  phase_current_t         next_held;
  logic signed [DW-1:0]   alpha;
  logic signed [DW-1:0]   beta;
  logic signed [DW-1:0]   integ_d;
  logic signed [DW-1:0]   integ_q;
  logic signed [DW-1:0]   next_integ_d;
  logic signed [DW-1:0]   next_integ_q;
  dq_t                    vcmd;
  dq_t                    next_vcmd;
  dq_t                    next_meas_dq;
  logic [CW-1:0]          duty [3];
  logic [CW-1:0]          next_duty [3];
  logic signed [DW-1:0]   q_target;
  logic signed [DW-1:0]   err_d;
  logic signed [DW-1:0]   err_q;
  logic signed [DW-1:0]   s_th;
  logic signed [DW-1:0]   c_th;

  // override wins over the servo output for diagnostics
  assign q_target = override_en ? override_q_cmd : servo_q_cmd;
  assign err_d    = direct_current_magnitude - meas_dq.d;
  assign err_q    = q_target - meas_dq.q;
  assign s_th     = sin_f(elec_angle);
  assign c_th     = sin_f(elec_angle + ANGLE_90);
  // clarke on two measured phases; phase c is implied by zero sum
  assign alpha    = held.ph_a;
  // the sum is saturated at full width first so a large phase b cannot wrap
  assign beta     = sat_f(mulq_f(sat_f(held.ph_a + 2 * held.ph_b), 16'sh49E7));
  assign loop_busy = (state != ST_IDLE);

  // one pass per phase tick with sample_valid; a tick while busy or without a sample is dropped, not queued
  always_comb begin
    logic signed [2*DW-1:0] ud;
    logic signed [2*DW-1:0] uq;
    logic signed [DW-1:0]   vph;
    logic [AW-1:0]          ang;
    logic signed [2*DW-1:0] off;
    ud = '0;
    uq = '0;
    vph = '0;
    ang = '0;
    off = '0;
    next_state   = state;
    next_held    = held;
    next_integ_d = integ_d;
    next_integ_q = integ_q;
    next_vcmd    = vcmd;
    next_meas_dq = meas_dq;
    for (int k = 0; k < 3; k++) begin
      next_duty[k] = duty[k];
    end
    case (state)
      ST_IDLE: begin
        if (!current_loop_enable) begin
          next_integ_d = '0;
          next_integ_q = '0;
          next_vcmd    = '0;
        end else if (phase_tick && sample_valid) begin
          next_held  = sample;
          next_state = ST_PARK;
        end
      end
      ST_PARK: begin
        // rotate into the field frame
        next_meas_dq.d = sat_f(mulq_f(alpha, c_th) + mulq_f(beta, s_th));
        next_meas_dq.q = sat_f(mulq_f(beta, c_th) - mulq_f(alpha, s_th));
        next_state     = ST_PI;
      end
      ST_PI: begin
        // the same kp and ki serve both axes
        next_integ_d = sat_f(integ_d + ((err_d * gains.ki) >>> GAIN_SHIFT));
        next_integ_q = sat_f(integ_q + ((err_q * gains.ki) >>> GAIN_SHIFT));
        ud = (err_d * gains.kp) >>> GAIN_SHIFT;
        uq = (err_q * gains.kp) >>> GAIN_SHIFT;
        next_vcmd.d = sat_f(ud + next_integ_d);
        next_vcmd.q = sat_f(uq + next_integ_q);
        next_state  = ST_INV;
      end
      ST_INV: begin
        // back to three phase voltages, 120 degrees apart
        for (int k = 0; k < 3; k++) begin
          ang = elec_angle + ((k == 0) ? 10'h000 : (k == 1) ? ANGLE_240 : ANGLE_120);
          vph = sat_f(mulq_f(vcmd.d, sin_f(ang + ANGLE_90))
                      - mulq_f(vcmd.q, sin_f(ang)));
          off = (vph >>> CMD_SHIFT) + $signed({21'h0, PWM_HALF});
          // clamp so duty never wraps past the carrier ends
          if (off < 0) begin
            next_duty[k] = PWM_ZERO;
          end else if (off > $signed({21'h0, PWM_MAX})) begin
            next_duty[k] = PWM_MAX;
          end else begin
            next_duty[k] = off[CW-1:0];
          end
        end
        next_state = ST_LOAD;
      end
      ST_LOAD: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state   <= ST_IDLE;
      held    <= '0;
      integ_d <= '0;
      integ_q <= '0;
      vcmd    <= '0;
      meas_dq <= '0;
      for (int k = 0; k < 3; k++) begin
        duty[k] <= PWM_HALF;
      end
    end else begin
      state   <= next_state;
      held    <= next_held;
      integ_d <= next_integ_d;
      integ_q <= next_integ_q;
      vcmd    <= next_vcmd;
      meas_dq <= next_meas_dq;
      for (int k = 0; k < 3; k++) begin
        duty[k] <= next_duty[k];
      end
    end
  end

  // ==========================================================================
  // three half-bridge outputs
  pwm_pair_t pairs [3];

  generate
    for (genvar g = 0; g < 3; g++) begin : g_phase
      pwm_phase u_phase (
        .mclk    (mclk),
        .resetn  (resetn),
        .enable  (current_loop_enable),
        .duty    (duty[g]),
        .carrier (carrier),
        .pair    (pairs[g])
      );
    end
  endgenerate

  assign pwm_a = pairs[0];
  assign pwm_b = pairs[1];
  assign pwm_c = pairs[2];

  // ==========================================================================
  // checks
  property p_top_bot_exclusive;
    @(posedge mclk) disable iff (!resetn)
      !(pwm_a.top && pwm_a.bot) && !(pwm_b.top && pwm_b.bot) && !(pwm_c.top && pwm_c.bot);
  endproperty
  a_top_bot_exclusive: assert property (p_top_bot_exclusive)
    else $error("top and bottom both on");

  property p_pwm_compare;
    @(posedge mclk) disable iff (!resetn)
      current_loop_enable ##1 current_loop_enable |->
        pwm_a.top == $past(duty[0] > carrier);
  endproperty
  a_pwm_compare: assert property (p_pwm_compare)
    else $error("pwm does not follow compare");

  property p_disabled_no_loop;
    @(posedge mclk) disable iff (!resetn)
      !current_loop_enable && state == ST_IDLE |=> state == ST_IDLE && integ_d == 0;
  endproperty
  a_disabled_no_loop: assert property (p_disabled_no_loop)
    else $error("loop ran while disabled");

  property p_pass_length;
    @(posedge mclk) disable iff (!resetn)
      state == ST_PARK |-> ##1 state == ST_PI ##1 state == ST_INV ##1 state == ST_LOAD;
  endproperty
  a_pass_length: assert property (p_pass_length)
    else $error("loop pass out of sequence");

  property p_duty_range;
    @(posedge mclk) disable iff (!resetn)
      duty[0] <= PWM_MAX && duty[1] <= PWM_MAX && duty[2] <= PWM_MAX;
  endproperty
  a_duty_range: assert property (p_duty_range)
    else $error("duty outside carrier range");

  property p_carrier_range;
    @(posedge mclk) disable iff (!resetn)
      (carrier <= PWM_MAX) and (carrier == PWM_MAX |=> carrier == PWM_MAX - 11'h001);
  endproperty
  a_carrier_range: assert property (p_carrier_range)
    else $error("carrier left its range");

  property p_start_on_tick;
    @(posedge mclk) disable iff (!resetn)
      state == ST_IDLE && phase_tick && sample_valid && current_loop_enable
        |=> state == ST_PARK && held == $past(sample);
  endproperty
  a_start_on_tick: assert property (p_start_on_tick)
    else $error("sample not taken on phase tick");

  property p_shared_gains;
    @(posedge mclk) disable iff (!resetn)
      state == ST_PI && err_d == err_q |=> integ_d - $past(integ_d) == integ_q - $past(integ_q)
        || integ_d == SAT_POS || integ_d == SAT_NEG
        || integ_q == SAT_POS || integ_q == SAT_NEG;
  endproperty
  a_shared_gains: assert property (p_shared_gains)
    else $error("axes use different gains");

endmodule : field_oriented_current_loop

// [foc_pkg.sv]
// package of constants and carrier types for the field-oriented current loop
package foc_pkg;

  // ==========================================================================
  // widths
  localparam int DW  = 16;                    // sample and command width
  localparam int AW  = 10;                    // angle width (full turn = 1024)
  localparam int CW  = 11;                    // pwm counter width
  localparam int GW  = 16;                    // gain width, Q8.8

  // ==========================================================================
  // pwm carrier: counter runs 0..PWM_MAX..0 (up/down)
  localparam logic [CW-1:0] PWM_MAX   = 11'h3FF;
  localparam logic [CW-1:0] PWM_ZERO  = 11'h000;
  localparam logic [CW-1:0] PWM_HALF  = 11'h200;
  localparam int            GAIN_SHIFT = 8;
  localparam int            CMD_SHIFT  = 6;   // voltage units to counter units
  localparam logic signed [DW-1:0] SAT_POS = 16'sh7FFF;
  localparam logic signed [DW-1:0] SAT_NEG = -16'sh7FFF;
  localparam logic [AW-1:0] ANGLE_120 = 10'h155;
  localparam logic [AW-1:0] ANGLE_240 = 10'h2AB;
  localparam logic [AW-1:0] ANGLE_90  = 10'h100;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic signed [DW-1:0] ph_a;
    logic signed [DW-1:0] ph_b;
  } phase_current_t;

  typedef struct packed {
    logic signed [DW-1:0] d;
    logic signed [DW-1:0] q;
  } dq_t;

  typedef struct packed {
    logic top;
    logic bot;
  } pwm_pair_t;

  typedef struct packed {
    logic signed [GW-1:0] kp;
    logic signed [GW-1:0] ki;
  } gains_t;

  // loop sequencer states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_PARK  = 5'b00010,
    ST_PI    = 5'b00100,
    ST_INV   = 5'b01000,
    ST_LOAD  = 5'b10000
  } seq_state_t;

endpackage : foc_pkg

// [pwm_phase.sv]
// one phase of pwm: compare against the shared triangle counter
module pwm_phase
  import foc_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            resetn,
  input  wire logic            enable,
  input  wire logic [CW-1:0]   duty,
  input  wire logic [CW-1:0]   carrier,
  output pwm_pair_t            pair
);

  pwm_pair_t next_pair;

  // compare; both switches off while disabled so the bridge floats
  always_comb begin
    next_pair.top = enable && (duty > carrier);
    next_pair.bot = enable && !(duty > carrier);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pair <= '0;
    end else begin
      pair <= next_pair;
    end
  end

endmodule : pwm_phase

// [amp_adc_model.sv]
// half-bridge amplifier and current-sense adc model facing the current loop
module amp_adc_model
  import foc_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 slow,
  input  wire logic signed [DW-1:0] cur_a,
  input  wire logic signed [DW-1:0] cur_b,
  input  wire pwm_pair_t            pwm_a,
  input  wire pwm_pair_t            pwm_b,
  input  wire pwm_pair_t            pwm_c,
  output logic                      sample_valid,
  output phase_current_t            sample,
  output logic                      shoot
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] conv;

  // ==========================================================================
  // adc: a slow converter finishes one word in four cycles; between words
  // the data lines invert every cycle, showing the last word again in the middle one
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      conv <= 2'h0;
      sample_valid <= 1'b0;
      sample <= '0;
    end else begin
      conv <= conv + 2'h1;
      sample_valid <= !slow || (conv == 2'h3);
      if (!slow || conv == 2'h3) begin
        sample <= {cur_a, cur_b};
      end else begin
        sample <= ~sample;
      end
    end
  end

  // both switches of one leg on together would short the supply rail
  assign shoot = (pwm_a.top && pwm_a.bot) || (pwm_b.top && pwm_b.bot) ||
                 (pwm_c.top && pwm_c.bot);
endmodule : amp_adc_model

// [field_oriented_current_loop_tb.sv]
// self-checking bench for the field-oriented current loop
module field_oriented_current_loop_tb import foc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [11:0] a; logic [1:0] rel; logic en;} pwm_exp_t;
  logic                 mclk = 0, resetn = 0, phase_tick = 0, slow = 1, override_en = 0;
  logic                 en = 0, sample_valid, loop_busy, shoot;
  logic [AW-1:0]        elec_angle = '0;
  logic signed [DW-1:0] servo_q_cmd = '0, override_q_cmd = '0, dcm = '0;
  logic signed [DW-1:0] cur_a = '0, cur_b = '0, x;
  gains_t               gains = '0;
  phase_current_t       sample;
  pwm_pair_t            pwm_a, pwm_b, pwm_c;
  dq_t                  meas_dq;
  int                   fails = 0, n_checks = 0, seed = 21, tick_per = 7, tick_cnt = 0;
  int                   run = 0, n_pass = 0, p0;
  pwm_exp_t             pwm_q[$];
  dq_t                  dq_q[$];

  field_oriented_current_loop dut (.mclk(mclk), .resetn(resetn), .phase_tick(phase_tick),
    .sample_valid(sample_valid), .sample(sample), .elec_angle(elec_angle),
    .servo_q_cmd(servo_q_cmd), .override_en(override_en), .override_q_cmd(override_q_cmd),
    .direct_current_magnitude(dcm), .current_loop_enable(en), .gains(gains),
    .pwm_a(pwm_a), .pwm_b(pwm_b), .pwm_c(pwm_c), .loop_busy(loop_busy), .meas_dq(meas_dq));
  amp_adc_model adc (.mclk(mclk), .resetn(resetn), .slow(slow), .cur_a(cur_a), .cur_b(cur_b),
    .pwm_a(pwm_a), .pwm_b(pwm_b), .pwm_c(pwm_c), .sample_valid(sample_valid),
    .sample(sample), .shoot(shoot));

  always #25 mclk = ~mclk;

  // ==========================================================================
  // helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  // converters round, so the field-frame figures are allowed two lsb of slack
  function automatic logic near(input logic signed [15:0] s, input logic signed [15:0] e);
    int df;
    df = int'(s) - int'(e);
    return (^s !== 1'bx) && df <= 2 && df >= -2;
  endfunction : near

  // settle a command set, then let the pwm monitor judge one carrier period
  task automatic pwm_case(input logic [15:0] d, srv, ovr, input logic ov,
                          input logic [11:0] a, input logic [1:0] rel);
    dcm = d;
    servo_q_cmd = srv;
    override_q_cmd = ovr;
    override_en = ov;
    cyc(60);
    pwm_q.push_back('{a, rel, en});
    wait (pwm_q.size() == 0);
    cyc(1);
  endtask : pwm_case

  // ==========================================================================
  // phase clock ticks from the falling edge
  always @(negedge mclk) begin
    tick_cnt <= tick_cnt + 1;
    phase_tick <= (tick_cnt % tick_per) == 0;
  end

  // busy length, pass count and field-frame results seen at the end of a pass
  always @(negedge mclk) begin
    if (loop_busy === 1'b1) run++;
    else if (run != 0) begin
      check(run, 4);
      n_pass++;
      if (dq_q.size() > 0) check(near(meas_dq.d, dq_q[0].d) && near(meas_dq.q, dq_q[0].q), 1);
      if (dq_q.size() > 0) void'(dq_q.pop_front());
      run = 0;
    end
    if (shoot === 1'b1) check(shoot, 0);
  end

  // high-side on-time over one whole carrier period gives 2*duty-1 cycles, or none at duty 0
  initial begin : pwm_mon
    logic [11:0] c[6];
    logic [5:0]  w;
    pwm_exp_t    e;
    forever begin
      wait (pwm_q.size() > 0);
      c = '{default: '0};
      repeat (2046) begin
        @(negedge mclk);
        w = {pwm_a, pwm_b, pwm_c};
        for (int i = 0; i < 6; i++) c[i] += w[5-i];
      end
      e = pwm_q.pop_front();
      check(c[0], e.a);
      check(c[1], e.en ? 12'd2046 - e.a : 12'h0);
      check(c[3], e.en ? 12'd2046 - c[2] : 12'h0);
      check(c[5], e.en ? 12'd2046 - c[4] : 12'h0);
      check(c[2] == c[4] ? 0 : (c[2] > c[4] ? 1 : 2), e.rel);
      if (!e.en) check(c[2] | c[4], 0);
    end
  end

  // watchdog sized well past the planned run
  initial begin
    #(60000 * 50);
    fails++;
    finish_test();
  end

  // ==========================================================================
  // main sequence
  initial begin
    cyc(3);
    resetn = 1;
    pwm_case(16'h0, 16'h0, 16'h0, 0, 12'h0, 0);
    check(n_pass, 0);
    en = 1;
    gains = {16'h0400, 16'h0000};
    pwm_case(16'h0, 16'h0, 16'h0, 0, 12'd1023, 0);
    pwm_case(16'h0, 16'h0, 16'h4000, 1, 12'd1023, 1);
    pwm_case(16'h0, -16'sh4000, 16'h4000, 0, 12'd1023, 2);
    gains = {16'h7FFF, 16'h7FFF};
    pwm_case(16'h7000, 16'h0, 16'h0, 0, 12'd2045, 0);
    pwm_case(-16'sh7000, 16'h0, 16'h0, 0, 12'h0, 0);
    // integrators hold their saturated d value until the loop is disabled
    en = 0;
    cyc(8);
    en = 1;
    pwm_case(16'h0, 16'h0, 16'h7000, 1, 12'd1023, 1);
    // equal errors on both axes with a small ki exercise the shared gain check
    dcm = 16'h0100;
    override_q_cmd = 16'h0100;
    gains = {16'h0000, 16'h0010};
    cyc(60);
    slow = 0;
    gains = '0;
    for (int i = 0; i < 4; i++) begin
      x = $random(seed) % 2048;
      x = x & ~16'sh1;
      cur_a = x;
      cur_b = -(x / 2);
      elec_angle = i[0] ? ANGLE_90 : 10'h000;
      cyc(12);
      dq_q.push_back(i[0] ? {16'h0, -x} : {x, 16'h0});
      wait (dq_q.size() == 0);
    end
    p0 = n_pass;
    tick_per = 2;
    cyc(100);
    check((n_pass - p0) >= 14 && (n_pass - p0) <= 20, 1);
    finish_test();
  end
endmodule : field_oriented_current_loop_tb
